// >>> design/fprr_top.sv
// Purpose: Three fan PWM channels with rate, band and span settings and a
//          duty ramp limiter on channel 1, behind a classic Wishbone slave
// Assumes: Duty targets come from logic on the same clock; 8-bit duty, 255 = 100%
// Notes:   Notes on behaviour
// Notes on behaviour
// - Rate code picks low-frequency PWM rate
// - Rate code ignored in high-frequency band
// - Rate code resets to 100, 35.3 Hz
// - Bit 3 selects high or low band
// - Bits 7:4 hold the control span
// - Lock bit makes span registers read-only
// - Three-bit ramp code limits channel 1 slew
// - Ramp steps duty toward target gradually
// - Ramp steps 1..48 per slot, normal slot
// - Slow-down bit stretches ramp slot four times
`timescale 1ns/10ps
module fprr_top #(
  parameter logic [31:0] SLOT_CYC_A = 32'(fprr_pkg::SLOT_CYC_A),
  parameter logic [31:0] SLOT_CYC_B = 32'(fprr_pkg::SLOT_CYC_B),
  parameter logic [23:0] LF_PRE0    = fprr_pkg::lf_prescale(0),
  parameter logic [23:0] LF_PRE1    = fprr_pkg::lf_prescale(1),
  parameter logic [23:0] LF_PRE2    = fprr_pkg::lf_prescale(2),
  parameter logic [23:0] LF_PRE3    = fprr_pkg::lf_prescale(3),
  parameter logic [23:0] LF_PRE4    = fprr_pkg::lf_prescale(4),
  parameter logic [23:0] LF_PRE5    = fprr_pkg::lf_prescale(5),
  parameter logic [23:0] LF_PRE7    = fprr_pkg::lf_prescale(7),
  parameter logic [23:0] HF_PRE     = 24'(fprr_pkg::HF_PRESCALE)
) (
  // Clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST_N,
  // Wishbone slave
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [9:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  // Duty targets from the control loop
  input  wire logic [7:0]  I_DUTY1,
  input  wire logic [7:0]  I_DUTY2,
  input  wire logic [7:0]  I_DUTY3,
  // Fan drive and span settings
  output logic      [2:0]  O_FAN_DRIVE_CHANNEL,
  output logic      [3:0]  O_SPAN1,
  output logic      [3:0]  O_SPAN2,
  output logic      [3:0]  O_SPAN3,
  output logic      [7:0]  O_DUTY1_APPLIED
);

  logic [7:0]  span_pwm_rate_select_reg [0:2];
  logic [7:0]  ramp_one_reg;
  logic [7:0]  config_six_reg;
  logic        lock_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic [7:0]  ramp_duty_reg;
  logic [31:0] slot_cnt_reg;
  logic [1:0]  slow_cnt_reg;
  logic [7:0]  duty_in [0:2];
  logic [7:0]  duty_eff [0:2];
  logic [23:0] lf_pre [0:7];
  logic        req;
  logic        wr_lane0;
  logic [7:0]  idx;
  logic        ramp_en;
  logic [2:0]  ramp_code;
  logic [7:0]  ramp_step;
  logic [31:0] slot_len;
  logic        slot_end;
  logic        slow_sel;

  assign lf_pre[0] = LF_PRE0;
  assign lf_pre[1] = LF_PRE1;
  assign lf_pre[2] = LF_PRE2;
  assign lf_pre[3] = LF_PRE3;
  assign lf_pre[4] = LF_PRE4;
  assign lf_pre[5] = LF_PRE5;
  assign lf_pre[6] = LF_PRE5;
  assign lf_pre[7] = LF_PRE7;

  assign duty_in[0] = I_DUTY1;
  assign duty_in[1] = I_DUTY2;
  assign duty_in[2] = I_DUTY3;

  // Bus decode; single-cycle ack, so a held request is answered once per cycle pair
  assign req      = I_WB_CYC && I_WB_STB && !ack_reg;
  assign wr_lane0 = req && I_WB_WE && I_WB_SEL[0];
  assign idx      = I_WB_ADR[9:2];

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      rdat_reg <= 32'h0000_0000;
    end else if (req && !I_WB_WE) begin
      unique case (idx)
        fprr_pkg::IDX_SPAN_FREQ1: rdat_reg <= {24'h00_0000, span_pwm_rate_select_reg[0]};
        fprr_pkg::IDX_SPAN_FREQ2: rdat_reg <= {24'h00_0000, span_pwm_rate_select_reg[1]};
        fprr_pkg::IDX_SPAN_FREQ3: rdat_reg <= {24'h00_0000, span_pwm_rate_select_reg[2]};
        fprr_pkg::IDX_RAMP_ONE:   rdat_reg <= {24'h00_0000, ramp_one_reg};
        fprr_pkg::IDX_CONFIG_SIX: rdat_reg <= {24'h00_0000, config_six_reg};
        fprr_pkg::IDX_CONFIG_ONE: rdat_reg <= {30'h0000_0000, lock_reg, 1'b0};
        fprr_pkg::IDX_RAMP_STAT:  rdat_reg <= {24'h00_0000, ramp_duty_reg};
        default:                  rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Span and rate registers, frozen once the lock is set
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_span
      always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
          span_pwm_rate_select_reg[g] <= fprr_pkg::RST_SPAN_PWM_RATE_SELECT;
        end else if (wr_lane0 && !lock_reg
                     && idx == fprr_pkg::IDX_SPAN_FREQ1 + 8'(g)) begin
          span_pwm_rate_select_reg[g] <= I_WB_DAT[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      ramp_one_reg <= fprr_pkg::RST_RAMP_ONE;
    end else if (wr_lane0 && !lock_reg && idx == fprr_pkg::IDX_RAMP_ONE) begin
      ramp_one_reg <= I_WB_DAT[7:0];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      config_six_reg <= fprr_pkg::RST_CONFIG;
    end else if (wr_lane0 && idx == fprr_pkg::IDX_CONFIG_SIX) begin
      config_six_reg <= I_WB_DAT[7:0];
    end
  end

  // Lock is write-once; only reset clears it, so software cannot unfreeze
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      lock_reg <= 1'b0;
    end else if (wr_lane0 && idx == fprr_pkg::IDX_CONFIG_ONE
                 && I_WB_DAT[fprr_pkg::FLD_LOCK_BIT]) begin
      lock_reg <= 1'b1;
    end
  end

  // Ramp limiter on channel 1
  assign ramp_en   = ramp_one_reg[fprr_pkg::FLD_RAMP_EN];
  assign ramp_code = ramp_one_reg[fprr_pkg::FLD_RAMP_LSB +: 3];
  assign ramp_step = fprr_pkg::RAMP_STEP[ramp_code];
  assign slot_len  = config_six_reg[fprr_pkg::FLD_SLOT_MODE] ? SLOT_CYC_B : SLOT_CYC_A;
  assign slow_sel  = config_six_reg[fprr_pkg::FLD_SLOW_LSB];
  assign slot_end  = (slot_cnt_reg >= slot_len - 32'h0000_0001);

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      slot_cnt_reg <= 32'h0000_0000;
    end else if (slot_end) begin
      slot_cnt_reg <= 32'h0000_0000;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 32'h0000_0001;
    end
  end

  // Slow-down counts four slots per step
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      slow_cnt_reg <= 2'h0;
    end else if (slot_end) begin
      slow_cnt_reg <= slow_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      ramp_duty_reg <= 8'h00;
    end else if (!ramp_en) begin
      ramp_duty_reg <= I_DUTY1;
    end else if (slot_end && (!slow_sel || slow_cnt_reg == 2'h3)) begin
      if (I_DUTY1 > ramp_duty_reg) begin
        ramp_duty_reg <= (I_DUTY1 - ramp_duty_reg > ramp_step)
                         ? ramp_duty_reg + ramp_step : I_DUTY1;
      end else if (I_DUTY1 < ramp_duty_reg) begin
        ramp_duty_reg <= (ramp_duty_reg - I_DUTY1 > ramp_step)
                         ? ramp_duty_reg - ramp_step : I_DUTY1;
      end
    end
  end

  assign duty_eff[0] = ramp_en ? ramp_duty_reg : I_DUTY1;
  assign duty_eff[1] = I_DUTY2;
  assign duty_eff[2] = I_DUTY3;

  // PWM generators: a prescaler ticks an 8-bit phase counter
  generate
    for (g = 0; g < 3; g++) begin : g_pwm
      logic [23:0] pre_cnt_reg;
      logic [7:0]  phase_reg;
      logic        drive_reg;
      logic [2:0]  rate;
      logic [23:0] pre_len;
      assign rate    = span_pwm_rate_select_reg[g][fprr_pkg::FLD_RATE_LSB +: 3];
      assign pre_len = span_pwm_rate_select_reg[g][fprr_pkg::FLD_BAND_BIT]
                       ? HF_PRE : lf_pre[rate];
      always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
          pre_cnt_reg <= 24'h00_0000;
          phase_reg   <= 8'h00;
        end else if (pre_cnt_reg >= pre_len - 24'h00_0001) begin
          pre_cnt_reg <= 24'h00_0000;
          phase_reg   <= (phase_reg == 8'hFE) ? 8'h00 : phase_reg + 8'h01;
        end else begin
          pre_cnt_reg <= pre_cnt_reg + 24'h00_0001;
        end
      end
      // Period of 255 phases so that duty 255 is a steady high
      always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
          drive_reg <= 1'b0;
        end else begin
          drive_reg <= phase_reg < duty_eff[g];
        end
      end
      assign O_FAN_DRIVE_CHANNEL[g] = drive_reg;
    end
  endgenerate

  // Reserved span code reports as its neighbour
  function automatic logic [3:0] span_of(input logic [7:0] r);
    span_of = (r[7:4] == fprr_pkg::SPAN_RESERVED) ? fprr_pkg::SPAN_FALLBACK : r[7:4];
  endfunction

  assign O_SPAN1         = span_of(span_pwm_rate_select_reg[0]);
  assign O_SPAN2         = span_of(span_pwm_rate_select_reg[1]);
  assign O_SPAN3         = span_of(span_pwm_rate_select_reg[2]);
  assign O_DUTY1_APPLIED = ramp_duty_reg;
  assign O_WB_DAT        = rdat_reg;
  assign O_WB_ACK        = ack_reg;

endmodule

// >>> pkg/fprr_pkg.sv
// Purpose: Shared constants for the fan PWM rate, span and ramp block
// Assumes: 100 MHz reference clock, Wishbone word index = byte address / 4
// Notes:   Index values are register indices, byte address is four times the index
package fprr_pkg;
  // Clock and timing
  localparam longint unsigned CLK_HZ          = 64'd100_000_000;
  localparam longint unsigned RAMP_SWEEP_A_MS = 64'd37_500;
  localparam longint unsigned RAMP_SWEEP_B_MS = 64'd52_200;
  localparam longint unsigned DUTY_STEPS      = 64'd255;
  localparam longint unsigned SLOT_CYC_A      = RAMP_SWEEP_A_MS * (CLK_HZ / 64'd1000) / DUTY_STEPS;
  localparam longint unsigned SLOT_CYC_B      = RAMP_SWEEP_B_MS * (CLK_HZ / 64'd1000) / DUTY_STEPS;
  localparam int unsigned     SLOW_FACTOR     = 4;
  localparam int unsigned     HF_PRESCALE     = 16;

  // Register indices
  localparam logic [7:0] IDX_SPAN_FREQ1 = 8'h5F;
  localparam logic [7:0] IDX_SPAN_FREQ2 = 8'h60;
  localparam logic [7:0] IDX_SPAN_FREQ3 = 8'h61;
  localparam logic [7:0] IDX_RAMP_ONE   = 8'h62;
  localparam logic [7:0] IDX_CONFIG_SIX = 8'h10;
  localparam logic [7:0] IDX_CONFIG_ONE = 8'h40;
  localparam logic [7:0] IDX_RAMP_STAT  = 8'h30;

  // Reset values
  localparam logic [7:0] RST_SPAN_PWM_RATE_SELECT  = 8'hC4;
  localparam logic [7:0] RST_RAMP_ONE   = 8'h00;
  localparam logic [7:0] RST_CONFIG     = 8'h00;

  // Field positions
  localparam int unsigned FLD_RATE_LSB   = 0;
  localparam int unsigned FLD_BAND_BIT   = 3;
  localparam int unsigned FLD_SPAN_LSB   = 4;
  localparam int unsigned FLD_RAMP_LSB   = 0;
  localparam int unsigned FLD_RAMP_EN    = 3;
  localparam int unsigned FLD_LOCK_BIT   = 1;
  localparam int unsigned FLD_SLOW_LSB   = 0;
  localparam int unsigned FLD_SLOT_MODE  = 7;

  // Reserved codes and the neighbours they fall back to
  localparam logic [2:0] RATE_RESERVED  = 3'h6;
  localparam logic [2:0] RATE_FALLBACK  = 3'h5;
  localparam logic [3:0] SPAN_RESERVED  = 4'h6;
  localparam logic [3:0] SPAN_FALLBACK  = 4'h5;

  // Low-frequency rates in centihertz, indexed by rate code
  localparam longint unsigned LF_CHZ [0:7] = '{
    64'd1100, 64'd1470, 64'd2210, 64'd2940, 64'd3530, 64'd5880, 64'd5880, 64'd8820};

  // Duty step per time slot, indexed by ramp code
  localparam logic [7:0] RAMP_STEP [0:7] = '{
    8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h30};

  function automatic logic [23:0] lf_prescale(input int unsigned code);
    lf_prescale = 24'(CLK_HZ * 64'd100 / (LF_CHZ[code] * 64'd256));
  endfunction
endpackage

// >>> verification/fprr_chk.sv
// Purpose: Port assertions for the fan PWM block
// Assumes: Bound to fprr_top, one clock domain
// Notes:   Ramp enable is invisible here, so only upward travel toward the target is checked
`timescale 1ns/10ps
module fprr_chk (
  // Clock and bus
  input wire logic        I_REF_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        O_WB_ACK,
  // Duty and drive
  input wire logic [7:0]  I_DUTY1,
  input wire logic [7:0]  I_DUTY2,
  input wire logic [2:0]  O_FAN_DRIVE_CHANNEL,
  input wire logic [3:0]  O_SPAN1,
  input wire logic [3:0]  O_SPAN2,
  input wire logic [7:0]  O_DUTY1_APPLIED
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_take;
    I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence
  sequence s_answer;
    O_WB_ACK ##1 !O_WB_ACK;
  endsequence
  AST_ACK_NEXT: assert property (s_take |=> s_answer)
    else $error("ack not a one cycle answer");
  AST_DAT_UPPER: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_SPAN_RESET: assert property ($rose(I_RST_N) |-> O_SPAN1 == 4'hC && O_SPAN2 == 4'hC)
    else $error("span not at default after reset");
  AST_SPAN_RSVD: assert property (O_SPAN1 != 4'h6 && O_SPAN2 != 4'h6)
    else $error("reserved span code reported");
  AST_SPAN_CAUSE: assert property ($changed(O_SPAN1) |->
    $past(I_WB_CYC && I_WB_STB && !O_WB_ACK && I_WB_WE))
    else $error("span changed without a write");
  AST_DUTY_UP: assert property (O_DUTY1_APPLIED < I_DUTY1 && $stable(I_DUTY1) |=>
    O_DUTY1_APPLIED >= $past(O_DUTY1_APPLIED) && O_DUTY1_APPLIED <= $past(I_DUTY1))
    else $error("applied duty moved away from target");
  AST_CH1_IDLE: assert property (O_DUTY1_APPLIED == 8'h00 [*4] |-> !O_FAN_DRIVE_CHANNEL[0])
    else $error("channel 1 high at zero duty");
  AST_CH2_IDLE: assert property (I_DUTY2 == 8'h00 [*6] |-> !O_FAN_DRIVE_CHANNEL[1])
    else $error("channel 2 high at zero duty");
endmodule

// >>> verification/fprr_fan_model.sv
// Purpose: Fan load that measures PWM period and high time
// Assumes: PWM sampled on the system clock
// Notes:   Period and high time cover the last complete period only; edges count from the start
`timescale 1ns/10ps
module fprr_fan_model (
  input  wire logic i_clk,
  input  wire logic i_pwm,
  output int        o_period,
  output int        o_high,
  output int        o_edges
);
  int   cnt  = 0;
  int   hi   = 0;
  logic last = 1'b0;
  initial begin
    o_period = 0;
    o_high   = 0;
    o_edges  = 0;
  end
  always @(posedge i_clk) begin
    last <= i_pwm;
    if (i_pwm && !last) begin
      o_period <= cnt;
      o_high   <= hi;
      o_edges  <= o_edges + 1;
      cnt      <= 1;
      hi       <= 1;
    end else begin
      cnt <= cnt + 1;
      hi  <= hi + int'(i_pwm);
    end
  end
endmodule

// >>> verification/tb.sv
// Purpose: Register, rate, span, ramp and lock tests for fprr_top
// Assumes: Small prescale and slot values keep the run short
// Notes:   Every wait is bounded; a timeout counts as a mismatch
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, g, e); end end
module tb;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic [7:0]  duty1 = 8'h00, duty2 = 8'h00, duty3 = 8'h80, applied, rdat, v;
  logic [3:0]  sel = 4'hF;
  // Short prescale and slot lengths keep each PWM period and ramp slot quick
  localparam logic [31:0] SLOT_A = 32'h14;
  localparam logic [31:0] SLOT_B = 32'h1C;
  localparam logic [23:0] LFP [0:7] = '{24'h2, 24'h3, 24'h4, 24'h5, 24'h6, 24'h7, 24'h7, 24'h8};
  localparam logic [23:0] HFP = 24'h1;
  logic [2:0]  drive;
  logic [3:0]  span1, span2, span3;
  int          fail_count = 0, comparisons = 0, period, high, edges, n;
  int          pre [0:8] = '{2, 3, 4, 5, 6, 7, 7, 8, 1};
  logic [9:0]  adr_t [0:4] = '{10'h17C, 10'h180, 10'h184, 10'h188, 10'h3FC};
  logic [7:0]  exp_t [0:4] = '{8'hC4, 8'hC4, 8'hC4, 8'h00, 8'h00};
  always #5 clk = ~clk;
  fprr_top #(.SLOT_CYC_A(SLOT_A), .SLOT_CYC_B(SLOT_B), .LF_PRE0(LFP[0]), .LF_PRE1(LFP[1]),
    .LF_PRE2(LFP[2]), .LF_PRE3(LFP[3]), .LF_PRE4(LFP[4]), .LF_PRE5(LFP[5]), .LF_PRE7(LFP[7]),
    .HF_PRE(HFP)) DUT (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat_w), .O_WB_DAT(dat_r),
    .O_WB_ACK(ack), .I_DUTY1(duty1), .I_DUTY2(duty2), .I_DUTY3(duty3),
    .O_FAN_DRIVE_CHANNEL(drive), .O_SPAN1(span1), .O_SPAN2(span2), .O_SPAN3(span3),
    .O_DUTY1_APPLIED(applied));
  fprr_fan_model FAN (.i_clk(clk), .i_pwm(drive[0]), .o_period(period), .o_high(high),
    .o_edges(edges));
  task automatic summarize();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int lim);
    @(posedge clk);
    n++;
    if (n > lim) begin fail_count++; summarize(); end
  endtask
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat_w} <= {1'b1, 1'b1, w, a, 24'h0, d};
    n = 0;
    do tick(50); while (ack !== 1'b1);
    rdat = dat_r[7:0];
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wait_change();
    v = applied;
    n = 0;
    while (applied === v) tick(900);
  endtask
  task automatic ramp(input logic [7:0] r, c6, st, input int iv);
    xfer(1, 10'h040, c6);
    xfer(1, 10'h188, r);
    duty1 <= (applied < 8'h80) ? 8'hFF : 8'h00;
    wait_change();
    wait_change();
    `CHK((applied > v) ? applied - v : v - applied, st)
    `CHK(n, iv)
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      xfer(0, adr_t[i], 8'h00);
      `CHK(rdat, exp_t[i])
    end
    `CHK(span1, 4'hC)
    duty1 <= 8'h80;
    duty2 <= 8'h80;
    for (int c = 0; c < 9; c++) begin
      xfer(1, 10'h17C, (c == 8) ? 8'hC8 : 8'hC0 | 8'(c));
      n = 0;
      v = 8'(edges);
      while (8'(edges) < v + 8'h03) tick(30000);
      `CHK(period, 255 * pre[c])
      `CHK(high, 128 * pre[c])
    end
    xfer(1, 10'h180, 8'h64);
    xfer(1, 10'h184, 8'hF4);
    `CHK(span2, 4'h5)
    `CHK(span3, 4'hF)
    sel <= 4'hE;
    xfer(1, 10'h180, 8'hF4);
    sel <= 4'hF;
    xfer(0, 10'h180, 8'h00);
    `CHK(rdat, 8'h64)
    duty3 <= 8'h00;
    repeat (3) @(posedge clk);
    `CHK(drive[2], 1'b0)
    ramp(8'h0B, 8'h00, 8'h04, 20);
    ramp(8'h0F, 8'h01, 8'h30, 80);
    ramp(8'h09, 8'h80, 8'h02, 28);
    xfer(1, 10'h100, 8'h02);
    xfer(1, 10'h17C, 8'h55);
    xfer(0, 10'h17C, 8'h00);
    `CHK(rdat, 8'hC8)
    xfer(1, 10'h188, 8'h00);
    xfer(0, 10'h188, 8'h00);
    `CHK(rdat, 8'h09)
    summarize();
  end
endmodule
bind fprr_top fprr_chk u_chk (.*);
